/* File: avmc_gain_mute.v */
// Purpose: Gain, mute, ramp and duty-cap control registers of a stereo amp
// Assumes: Register port is same-clock logic; rate family from rate detector
// Notes: Gains are in eighth-dB attenuation units; 0 means +24 dB
// Notes: One coarse code is four units, so 0x30 sits at 0x0C0
// Notes: Master and channel codes add, and the fine trim adds 0 to 3 units
// Notes: Any all-ones code sends the channel to the full mute point 0x800
// Notes: The ramp walks the current gain one unit at a time toward target
// Notes: Ticks per unit follow the slew count; ramp time is approximate
// Notes: Step tick period follows the synchronised sample-rate family
// Notes: A clock error parks both channels at mute at once
// Notes: On recovery the soft path ramps, the hard path jumps in one step
// Notes: Reserved gain codes are not trapped; software must avoid them
`timescale 1ns/1ps
`include "avmc_regs.vh"
module avmc_gain_mute #(
  parameter STEP_CYC_32K = `AVMC_STEP_NS_32K / `AVMC_CLK_NS,
  parameter STEP_CYC_441K = `AVMC_STEP_NS_441K / `AVMC_CLK_NS,
  parameter STEP_CYC_48K = `AVMC_STEP_NS_48K / `AVMC_CLK_NS
) (
  input wire ref_clk,
  input wire sys_rst,
  input wire reg_wr,
  input wire reg_rd,
  input wire [7:0] reg_addr,
  input wire [7:0] reg_wdata,
  output reg [7:0] reg_rdata,
  input wire [1:0] rate_family,
  input wire clk_err,
  input wire soft_unmute_sel,
  output reg shutdown_active,
  output reg [1:0] half_duty,
  output reg [10:0] ch1_atten,
  output reg [10:0] ch2_atten,
  output reg ch1_muted,
  output reg ch2_muted,
  output reg [2:0] duty_cap,
  output reg ramp_busy
);
  // Register storage
  reg [7:0] shutdown_q;
  reg [7:0] soft_mute_q;
  reg [7:0] master_q;
  reg [7:0] ch1_q;
  reg [7:0] ch2_q;
  reg [7:0] trim_q;
  reg [7:0] ramp_q;
  reg [7:0] duty_q;

  // Synchroniser stages for the audio-domain inputs
  reg [1:0] fam_s1_q;
  reg [1:0] fam_s2_q;
  reg err_s1_q;
  reg err_s2_q;
  reg unm_s1_q;
  reg unm_s2_q;

  // Ramp step timing
  reg [12:0] tick_cnt_q;
  reg [12:0] tick_per;
  reg tick;
  reg [11:0] steps;

  // Ramp targets and state
  reg [11:0] tgt1;
  reg [11:0] tgt2;
  reg [11:0] cur1_q;
  reg [11:0] cur2_q;
  reg [11:0] full_q;
  reg [11:0] acc_q;
  reg [11:0] inc1;
  reg [11:0] inc2;
  wire [11:0] mute_lvl;

  // Full attenuation point reached by a mute gain code or a clock error
  assign mute_lvl = 12'h800;

  // Register writes; trim write gated by its enable bit
  always @(posedge ref_clk) begin
    if (sys_rst) begin
      shutdown_q <= `AVMC_RST_SHUTDOWN;
      soft_mute_q <= `AVMC_RST_SOFT_MUTE;
      master_q <= `AVMC_RST_MASTER;
      ch1_q <= `AVMC_RST_CHAN;
      ch2_q <= `AVMC_RST_CHAN;
      trim_q <= `AVMC_RST_TRIM;
      ramp_q <= `AVMC_RST_RAMP;
      duty_q <= `AVMC_RST_DUTY;
    end else if (reg_wr) begin
      if (reg_addr == `AVMC_OFS_SHUTDOWN) begin
        shutdown_q <= {1'b0, reg_wdata[6], 6'h00};
      end else if (reg_addr == `AVMC_OFS_SOFT_MUTE) begin
        soft_mute_q <= {6'h00, reg_wdata[1:0]};
      end else if (reg_addr == `AVMC_OFS_MASTER) begin
        master_q <= reg_wdata;
      end else if (reg_addr == `AVMC_OFS_CH1) begin
        ch1_q <= reg_wdata;
      end else if (reg_addr == `AVMC_OFS_CH2) begin
        ch2_q <= reg_wdata;
      end else if (reg_addr == `AVMC_OFS_TRIM) begin
        if (reg_wdata[`AVMC_TRIM_WE_BIT]) begin
          trim_q <= {6'h00, reg_wdata[1:0]};
        end
      end else if (reg_addr == `AVMC_OFS_RAMP) begin
        ramp_q <= {5'h12, reg_wdata[2:0]};
      end else if (reg_addr == `AVMC_OFS_DUTY) begin
        duty_q <= {5'h00, reg_wdata[2:0]};
      end
    end
  end

  // Read data registered; unmapped offsets read zero
  always @(posedge ref_clk) begin
    if (sys_rst) begin
      reg_rdata <= 8'h00;
    end else if (reg_rd) begin
      if (reg_addr == `AVMC_OFS_SHUTDOWN) begin
        reg_rdata <= shutdown_q;
      end else if (reg_addr == `AVMC_OFS_SOFT_MUTE) begin
        reg_rdata <= soft_mute_q;
      end else if (reg_addr == `AVMC_OFS_MASTER) begin
        reg_rdata <= master_q;
      end else if (reg_addr == `AVMC_OFS_CH1) begin
        reg_rdata <= ch1_q;
      end else if (reg_addr == `AVMC_OFS_CH2) begin
        reg_rdata <= ch2_q;
      end else if (reg_addr == `AVMC_OFS_TRIM) begin
        reg_rdata <= trim_q;
      end else if (reg_addr == `AVMC_OFS_RAMP) begin
        reg_rdata <= ramp_q;
      end else if (reg_addr == `AVMC_OFS_DUTY) begin
        reg_rdata <= duty_q;
      end else begin
        reg_rdata <= 8'h00;
      end
    end
  end

  // Synchronisers for inputs from the audio clock domain
  always @(posedge ref_clk) begin
    if (sys_rst) begin
      fam_s1_q <= 2'd0;
      fam_s2_q <= 2'd0;
      err_s1_q <= 1'b0;
      err_s2_q <= 1'b0;
      unm_s1_q <= 1'b0;
      unm_s2_q <= 1'b0;
    end else begin
      fam_s1_q <= rate_family;
      fam_s2_q <= fam_s1_q;
      err_s1_q <= clk_err;
      err_s2_q <= err_s1_q;
      unm_s1_q <= soft_unmute_sel;
      unm_s2_q <= unm_s1_q;
    end
  end

  // Step period by rate family and step count by slew code
  always @* begin
    if (fam_s2_q == `AVMC_FAM_32K) begin
      tick_per = STEP_CYC_32K[12:0];
    end else if (fam_s2_q == `AVMC_FAM_441K) begin
      tick_per = STEP_CYC_441K[12:0];
    end else begin
      tick_per = STEP_CYC_48K[12:0];
    end
    case (ramp_q[2:0])
      3'b000: steps = `AVMC_STEPS_512;
      3'b010: steps = `AVMC_STEPS_2048;
      3'b011: steps = `AVMC_STEPS_256;
      default: steps = `AVMC_STEPS_1024; // Reserved codes act as 1024
    endcase
    tick = (tick_cnt_q >= tick_per - 13'd1);
  end

  // Step tick counter
  always @(posedge ref_clk) begin
    if (sys_rst || tick) begin
      tick_cnt_q <= 13'd0;
    end else begin
      tick_cnt_q <= tick_cnt_q + 13'd1;
    end
  end

  // Combined attenuation target of channel one, eighth-dB units
  always @* begin
    tgt1 = {2'b00, master_q, 2'b00} + {2'b00, ch1_q, 2'b00}
      + {10'd0, trim_q[1:0]};
    if (master_q == `AVMC_GAIN_MUTE || ch1_q == `AVMC_GAIN_MUTE) begin
      tgt1 = mute_lvl;
    end
    // A clock error parks the channel at full mute
    if (err_s2_q) begin
      tgt1 = mute_lvl;
    end
  end

  // Combined attenuation target of channel two, eighth-dB units
  always @* begin
    tgt2 = {2'b00, master_q, 2'b00} + {2'b00, ch2_q, 2'b00}
      + {10'd0, trim_q[1:0]};
    if (master_q == `AVMC_GAIN_MUTE || ch2_q == `AVMC_GAIN_MUTE) begin
      tgt2 = mute_lvl;
    end
    // A clock error parks the channel at full mute
    if (err_s2_q) begin
      tgt2 = mute_lvl;
    end
  end

  // Distance still to travel; nonzero means a ramp is running
  always @* begin
    inc1 = (tgt1 > cur1_q) ? tgt1 - cur1_q : cur1_q - tgt1;
    inc2 = (tgt2 > cur2_q) ? tgt2 - cur2_q : cur2_q - tgt2;
  end

  // Ramp: one unit per steps/256 ticks, or one jump on hard unmute
  always @(posedge ref_clk) begin
    if (sys_rst) begin
      cur1_q <= mute_lvl;
      cur2_q <= mute_lvl;
      full_q <= 12'd0;
      acc_q <= 12'd0;
    end else if (err_s2_q) begin
      cur1_q <= mute_lvl;
      cur2_q <= mute_lvl;
      full_q <= {11'd0, ~unm_s2_q};
    end else if (full_q[0]) begin
      cur1_q <= tgt1; // Hard unmute, single step
      cur2_q <= tgt2;
      full_q <= 12'd0;
    end else if (tick) begin
      // One unit moves every steps/256 ticks; count the ticks in acc_q
      acc_q <= acc_q + 12'd1;
      if (acc_q >= (steps >> 8) - 12'd1) begin
        acc_q <= 12'd0;
        if (cur1_q < tgt1) cur1_q <= cur1_q + 12'd1;
        else if (cur1_q > tgt1) cur1_q <= cur1_q - 12'd1;
        if (cur2_q < tgt2) cur2_q <= cur2_q + 12'd1;
        else if (cur2_q > tgt2) cur2_q <= cur2_q - 12'd1;
      end
    end
  end

  // Shutdown, soft mute and duty cap follow their registers
  always @(posedge ref_clk) begin
    if (sys_rst) begin
      shutdown_active <= 1'b1;
      half_duty <= 2'b00;
      duty_cap <= 3'd0;
    end else begin
      shutdown_active <= shutdown_q[`AVMC_SHDN_BIT];
      half_duty <= soft_mute_q[1:0];
      duty_cap <= duty_q[2:0];
    end
  end

  // Channel one gain; full mute shows as all-ones attenuation
  always @(posedge ref_clk) begin
    if (sys_rst) begin
      ch1_atten <= 11'h7ff;
      ch1_muted <= 1'b1;
    end else begin
      ch1_atten <= cur1_q[11] ? 11'h7ff : cur1_q[10:0];
      ch1_muted <= cur1_q[11];
    end
  end

  // Channel two gain; full mute shows as all-ones attenuation
  always @(posedge ref_clk) begin
    if (sys_rst) begin
      ch2_atten <= 11'h7ff;
      ch2_muted <= 1'b1;
    end else begin
      ch2_atten <= cur2_q[11] ? 11'h7ff : cur2_q[10:0];
      ch2_muted <= cur2_q[11];
    end
  end

  // Ramp in progress on either channel
  always @(posedge ref_clk) begin
    if (sys_rst) begin
      ramp_busy <= 1'b0;
    end else begin
      ramp_busy <= (inc1 != 12'd0) || (inc2 != 12'd0);
    end
  end
endmodule

/* File: avmc_regs.vh */
// Purpose: Offsets, fields, reset values and timing of the gain/mute block
// Assumes: 8-bit registers on a byte-wide register port
// Notes: Ramp step periods are in nanoseconds at a 20 MHz clock
`ifndef AVMC_REGS_VH
`define AVMC_REGS_VH
`define AVMC_OFS_SHUTDOWN 8'h05
`define AVMC_OFS_SOFT_MUTE 8'h06
`define AVMC_OFS_MASTER 8'h07
`define AVMC_OFS_CH1 8'h08
`define AVMC_OFS_CH2 8'h09
`define AVMC_OFS_TRIM 8'h0a
`define AVMC_OFS_RAMP 8'h0e
`define AVMC_OFS_DUTY 8'h10
`define AVMC_SHDN_BIT 6
`define AVMC_TRIM_WE_BIT 7
`define AVMC_RST_SHUTDOWN 8'h40
`define AVMC_RST_SOFT_MUTE 8'h00
`define AVMC_RST_MASTER 8'hff
`define AVMC_RST_CHAN 8'h30
`define AVMC_RST_TRIM 8'h00
`define AVMC_RST_RAMP 8'h91
`define AVMC_RST_DUTY 8'h00
`define AVMC_GAIN_MUTE 8'hff
`define AVMC_GAIN_MIN 8'hce
`define AVMC_CLK_NS 50
`define AVMC_STEP_NS_32K 125000
`define AVMC_STEP_NS_441K 90700
`define AVMC_STEP_NS_48K 83300
`define AVMC_STEPS_512 12'd512
`define AVMC_STEPS_1024 12'd1024
`define AVMC_STEPS_2048 12'd2048
`define AVMC_STEPS_256 12'd256
`define AVMC_FAM_32K 2'd0
`define AVMC_FAM_441K 2'd1
`define AVMC_FAM_48K 2'd2
`endif

/* File: avmc_gain_mute_sva.sv */
// Purpose: Port-level checks of the gain/mute register block
// Assumes: Writes to one register are never on adjacent edges
// Notes: Control outputs follow a write two edges later
`timescale 1ns/1ps
module avmc_gain_mute_sva (
  input wire ref_clk,
  input wire sys_rst,
  input wire reg_wr,
  input wire reg_rd,
  input wire [7:0] reg_addr,
  input wire [7:0] reg_wdata,
  input wire [7:0] reg_rdata,
  input wire clk_err,
  input wire shutdown_active,
  input wire [1:0] half_duty,
  input wire [10:0] ch1_atten,
  input wire [2:0] duty_cap
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (sys_rst);
  // Writes reach the control outputs
  a_shdn_write: assert property (
    reg_wr && reg_addr == 8'h05 |-> ##2 shutdown_active == $past(reg_wdata[6], 2))
    else $error("shutdown output wrong");
  a_mute_write: assert property (
    reg_wr && reg_addr == 8'h06 |-> ##2 half_duty == $past(reg_wdata[1:0], 2))
    else $error("half duty output wrong");
  a_cap_write: assert property (
    reg_wr && reg_addr == 8'h10 |-> ##2 duty_cap == $past(reg_wdata[2:0], 2))
    else $error("duty cap output wrong");
  // Read data agrees with the live outputs, reserved bits zero
  a_shdn_read: assert property (
    reg_rd && reg_addr == 8'h05 |=> reg_rdata == {1'b0, shutdown_active, 6'h00})
    else $error("shutdown readback wrong");
  a_mute_read: assert property (
    reg_rd && reg_addr == 8'h06 |=> reg_rdata == {6'h00, half_duty})
    else $error("soft mute readback wrong");
  a_cap_read: assert property (
    reg_rd && reg_addr == 8'h10 |=> reg_rdata == {5'h00, duty_cap})
    else $error("duty cap readback wrong");
  // Outputs leave reset in hard mute
  a_reset_state: assert property (
    $fell(sys_rst) |-> shutdown_active && half_duty == 2'h0 &&
      duty_cap == 3'h0 && ch1_atten == 11'h7ff)
    else $error("reset state wrong");
  a_clkerr_mute: assert property (
    $rose(clk_err) |-> ##[1:4] ch1_atten == 11'h7ff)
    else $error("clock error did not mute");
endmodule
bind avmc_gain_mute avmc_gain_mute_sva u_sva (.*);

/* File: avmc_host.sv */
// Purpose: Host controller model for the register strobe port
// Assumes: Strobes are sampled on the rising clock edge
// Notes: Drives after the falling edge; released lines show inverse
`timescale 1ns/1ps
module avmc_host (
  input wire ref_clk,
  output reg reg_wr,
  output reg reg_rd,
  output reg [7:0] reg_addr,
  output reg [7:0] reg_wdata,
  input wire [7:0] reg_rdata
);
  initial {reg_wr, reg_rd, reg_addr, reg_wdata} = 18'h0_0000;
  // One write strobe, address and data held across the edge
  task wr(input [7:0] a, input [7:0] v);
    begin
      @(negedge ref_clk);
      reg_addr = a;
      reg_wdata = v;
      reg_wr = 1'b1;
      @(negedge ref_clk);
      reg_wr = 1'b0;
      reg_addr = ~a;
      reg_wdata = ~v;
    end
  endtask
  // Read strobe, data taken two falling edges after the request
  task rd(input [7:0] a, output [7:0] v);
    begin
      @(negedge ref_clk);
      reg_addr = a;
      reg_rd = 1'b1;
      @(negedge ref_clk);
      reg_rd = 1'b0;
      reg_addr = ~a;
      @(negedge ref_clk);
      v = reg_rdata;
    end
  endtask
endmodule

/* File: testbench.sv */
// Purpose: Self-checking bench for the gain/mute register block
// Assumes: Ramp step period cut to two clocks
// Notes: Host model makes every register cycle
`timescale 1ns/1ps
module testbench;
  reg ref_clk = 0, sys_rst = 1, clk_err = 0, unm_sel = 1;
  wire reg_wr, reg_rd, shutdown_active, ch1_muted, ch2_muted, ramp_busy;
  wire [7:0] reg_addr, reg_wdata, reg_rdata;
  wire [1:0] half_duty;
  wire [10:0] ch1_atten, ch2_atten;
  wire [2:0] duty_cap;
  reg [7:0] d;
  integer err_count = 0, checks = 0, i, k;
  initial forever #25 ref_clk = ~ref_clk;
  avmc_host host (.ref_clk(ref_clk), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata));
  avmc_gain_mute #(.STEP_CYC_32K(2), .STEP_CYC_441K(2), .STEP_CYC_48K(2))
    DUT (.ref_clk(ref_clk), .sys_rst(sys_rst), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_rdata(reg_rdata), .rate_family(2'h2), .clk_err(clk_err),
    .soft_unmute_sel(unm_sel), .shutdown_active(shutdown_active),
    .half_duty(half_duty), .ch1_atten(ch1_atten), .ch2_atten(ch2_atten),
    .ch1_muted(ch1_muted), .ch2_muted(ch2_muted), .duty_cap(duty_cap),
    .ramp_busy(ramp_busy));
  task conclude;
    begin
      $display("errors %0d checks %0d", err_count, checks);
      if (err_count == 0 && checks > 0)
        $display("verification passed");
      else
        $display("verification failed");
      $finish;
    end
  endtask
  task chk(input string n, input [10:0] e, input [10:0] s);
    begin
      checks = checks + 1;
      if (s !== e) begin
        err_count = err_count + 1;
        $display("CHECK FAILED %s exp %h got %h", n, e, s);
      end
    end
  endtask
  // Read a register and compare the masked bits
  task rchk(input [7:0] a, input [7:0] e, input [7:0] m);
    begin
      host.rd(a, d);
      chk($sformatf("reg %h", a), {3'h0, e & m}, {3'h0, d & m});
    end
  endtask
  // Wait for the gain ramp to finish, bounded
  task settle;
    begin
      repeat (4) @(negedge ref_clk);
      for (i = 0; i < 20000 && ramp_busy !== 1'b0; i = i + 1)
        @(negedge ref_clk);
      if (i == 20000) begin
        err_count = err_count + 1;
        conclude;
      end
    end
  endtask
  task t_reset;
    begin
      rchk(8'h05, 8'h40, 8'hff);
      rchk(8'h06, 8'h00, 8'hff);
      rchk(8'h07, 8'hff, 8'hff);
      rchk(8'h08, 8'h30, 8'hff);
      rchk(8'h09, 8'h30, 8'hff);
      rchk(8'h0a, 8'h00, 8'hff);
      rchk(8'h0e, 8'h91, 8'hff);
      rchk(8'h10, 8'h00, 8'hff);
    end
  endtask
  task t_fields;
    begin
      for (k = 0; k < 8; k = k + 1) begin
        host.wr(8'h10, k[7:0]);
        rchk(8'h10, k[7:0], 8'hff);
        chk("duty_cap", k[2:0], duty_cap);
        host.wr(8'h06, k[7:0]);
        rchk(8'h06, k[7:0], 8'h03);
        chk("half_duty", k[1:0], half_duty);
        host.wr(8'h0e, {6'h24, k[1:0]});
        rchk(8'h0e, {6'h24, k[1:0]}, 8'hff);
      end
      host.wr(8'h0a, 8'h02);
      rchk(8'h0a, 8'h00, 8'h03);
      host.wr(8'h0a, 8'h81);
      rchk(8'h0a, 8'h01, 8'h03);
      host.wr(8'h05, 8'h00);
      rchk(8'h05, 8'h00, 8'hff);
      chk("shutdown", 0, shutdown_active);
    end
  endtask
  // Only legal gain codes are written
  task t_gain;
    begin
      host.wr(8'h07, 8'h30);
      settle;
      chk("ch1_muted", 0, ch1_muted);
      chk("ch1 unity", 11'h181, ch1_atten);
      chk("ch2 unity", 11'h181, ch2_atten);
      host.wr(8'h08, 8'h32);
      repeat (3) @(negedge ref_clk);
      chk("ramp_busy", 1, ramp_busy);
      settle;
      chk("ch1 step", 11'h189, ch1_atten);
      host.wr(8'h07, 8'h32);
      settle;
      chk("master add", 11'h191, ch1_atten);
      chk("ch2 master", 11'h189, ch2_atten);
      clk_err = 1'b1;
      repeat (6) @(negedge ref_clk);
      chk("err mute", 1, ch2_muted);
      clk_err = 1'b0;
      settle;
      chk("unmute", 11'h191, ch1_atten);
      unm_sel = 1'b0;
      clk_err = 1'b1;
      repeat (6) @(negedge ref_clk);
      clk_err = 1'b0;
      repeat (6) @(negedge ref_clk);
      chk("hard unmute", 11'h191, ch1_atten);
      host.wr(8'h07, 8'hff);
      settle;
      chk("master mute", 1, ch1_muted);
      chk("ch2 mute", 1, ch2_muted);
    end
  endtask
  initial begin
    repeat (8) @(negedge ref_clk);
    sys_rst = 1'b0;
    t_reset;
    t_fields;
    t_gain;
    conclude;
  end
endmodule
